// ===== usr_serial_port.sv
// synchronous serial port: master/slave reception and transmission
//
// Contract
// - continuous enable, or single enable in master mode, starts reception
// - data sampled on shift clock falling edge
// - single enable receives one word, stops
// - continuous enable receives until software clears
// - both enables set behaves as continuous
// - finished word enters fifo, sets receive flag
// - receive request gated by enable; flag not
// - receive flag read only, clears when empty
// - receive data is two-entry ordered fifo
// - full fifo at word end sets overrun
// - overrun clears only by clearing continuous enable
// - overrun blocks every transfer into fifo
// - ninth bit queued with byte, read advances
// - clock source clear selects external shift clock
// - slave mode works while core sleeps
// - first word sent, second waits, flag clear
// - second word loads after first, flag sets
// - flag with enable wakes core, vectors
// - master drives clock; baud idle when disabled
// - transmit flag set at handoff, cleared by write
// - transmit data changes on rising edge
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/1ps
`include "usr_map.svh"
module usr_serial_port #(
    parameter int RX_FIFO_DEPTH = 2,
    parameter int ADDR_W = 12
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic core_sleep,
    output logic rx_irq,
    output logic tx_irq,
    output logic wake_request,
    output logic branch_request,
    output logic [13:0] branch_vector,
    input wire logic shift_clock_pin_in,
    output logic shift_clock_pin_out,
    output logic shift_clock_pin_oe_n,
    input wire logic serial_data_pin_in,
    output logic serial_data_pin_out,
    output logic serial_data_pin_oe_n
);
    localparam int PW = (RX_FIFO_DEPTH > 1) ? $clog2(RX_FIFO_DEPTH) : 1;
    localparam logic [PW:0] FULL_CNT = (PW+1)'(RX_FIFO_DEPTH);
    localparam int IW = ADDR_W - 2;
    generate
        if (RX_FIFO_DEPTH < 2 || (RX_FIFO_DEPTH & (RX_FIFO_DEPTH - 1)) != 0
            || ADDR_W < 12) begin : g_bad
            $error("fifo depth must be a power of two, address 12 bits");
        end
    endgenerate
    function automatic logic hit(input logic [IW-1:0] idx,
                                 input logic [9:0] reg_idx);
        hit = (idx == IW'(reg_idx));
    endfunction
    // ---------------------------------------------------------------
    // bus slave
    // ---------------------------------------------------------------
    logic take;
    logic [IW-1:0] a_idx;
    logic wr_pend_reg;
    logic [IW-1:0] wr_idx_reg;
    logic [7:0] rd_mux;
    logic [31:0] hrdata_reg;
    logic pop;
    assign take = hsel && hready && htrans[1];
    assign a_idx = haddr[ADDR_W-1:2];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_reg;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_pend_reg <= 1'b0;
            wr_idx_reg <= '0;
            hrdata_reg <= 32'h0;
        end else begin
            wr_pend_reg <= take && hwrite && hsize == `USR_HSIZE_WORD;
            if (take) begin
                wr_idx_reg <= a_idx;
                hrdata_reg <= hwrite ? 32'h0 : {24'h0, rd_mux};
            end
        end
    end
    function automatic logic wr_hit(input logic pend,
                                    input logic [IW-1:0] idx,
                                    input logic [9:0] reg_idx);
        wr_hit = pend && hit(idx, reg_idx);
    endfunction
    // ---------------------------------------------------------------
    // control registers
    // ---------------------------------------------------------------
    logic [7:0] interrupt_control_reg, pie_reg, divisor_reg, wd;
    logic port_en_reg, rx9_en_reg, single_receive_enable_reg, continuous_receive_enable_reg, overrun_error_reg;
    logic clock_source_select_reg, tx9_reg, transmit_enable_reg, sync_reg, brgh_reg, transmit_ninth_bit_reg;
    logic word_done, push, overrun, full;
    assign wd = hwdata[7:0];
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            interrupt_control_reg <= `USR_RESET_BYTE;
            pie_reg <= `USR_RESET_BYTE;
            divisor_reg <= `USR_RESET_BYTE;
            {clock_source_select_reg, tx9_reg, transmit_enable_reg, sync_reg} <= 4'h0;
            {brgh_reg, transmit_ninth_bit_reg} <= 2'h0;
        end else begin
            if (wr_hit(wr_pend_reg, wr_idx_reg, `USR_IDX_INTERRUPT_CONTROL))
                interrupt_control_reg <= wd;
            if (wr_hit(wr_pend_reg, wr_idx_reg, `USR_IDX_IRQ_ENABLE))
                pie_reg <= wd;
            if (wr_hit(wr_pend_reg, wr_idx_reg, `USR_IDX_BAUD_DIVISOR))
                divisor_reg <= wd;
            if (wr_hit(wr_pend_reg, wr_idx_reg, `USR_IDX_TX_STATUS_CONTROL))
                begin
                clock_source_select_reg <= wd[`USR_CLOCK_SOURCE_BIT];
                tx9_reg <= wd[`USR_NINTH_TX_ENABLE_BIT];
                transmit_enable_reg <= wd[`USR_TX_ENABLE_BIT];
                sync_reg <= wd[`USR_SYNC_SELECT_BIT];
                brgh_reg <= wd[`USR_HIGH_BAUD_BIT];
                transmit_ninth_bit_reg <= wd[`USR_TX_NINTH_BIT];
            end
        end
    end
    // receive control, hardware clears single enable after one word unless continuous enable is set
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            {port_en_reg, rx9_en_reg, single_receive_enable_reg, continuous_receive_enable_reg} <= 4'h0;
        end else if (wr_hit(wr_pend_reg, wr_idx_reg,
                            `USR_IDX_RX_STATUS_CONTROL)) begin
            port_en_reg <= wd[`USR_PORT_ENABLE_BIT];
            rx9_en_reg <= wd[`USR_NINTH_RX_ENABLE_BIT];
            single_receive_enable_reg <= wd[`USR_SINGLE_RX_BIT];
            continuous_receive_enable_reg <= wd[`USR_CONT_RX_BIT];
        end else if (word_done && !continuous_receive_enable_reg && clock_source_select_reg) begin
            single_receive_enable_reg <= 1'b0;
        end
    end
    // overrun: set wins, cleared only while continuous enable is low
    always_ff @(posedge clk) begin
        if (!rst_n)
            overrun_error_reg <= 1'b0;
        else if (overrun)
            overrun_error_reg <= 1'b1;
        else if (!continuous_receive_enable_reg)
            overrun_error_reg <= 1'b0;
    end
    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic [2:0] ck_sync_reg, dt_sync_reg;
    logic ck_stable_reg, dt_stable_reg, ck_prev_reg;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ck_sync_reg <= 3'h0;
            dt_sync_reg <= 3'h0;
            ck_stable_reg <= 1'b0;
            dt_stable_reg <= 1'b0;
            ck_prev_reg <= 1'b0;
        end else begin
            ck_sync_reg <= {ck_sync_reg[1:0], shift_clock_pin_in};
            dt_sync_reg <= {dt_sync_reg[1:0], serial_data_pin_in};
            if (ck_sync_reg[1] == ck_sync_reg[2])
                ck_stable_reg <= ck_sync_reg[2];
            if (dt_sync_reg[1] == dt_sync_reg[2])
                dt_stable_reg <= dt_sync_reg[2];
            ck_prev_reg <= ck_stable_reg;
        end
    end
    // ---------------------------------------------------------------
    // baud generator and shift clock
    // ---------------------------------------------------------------
    logic port_on, rx_en, tx_on, brg_run, tick, clk_run;
    logic rise_ev, fall_ev, ck_reg, tx_busy_reg;
    logic [7:0] baud_cnt_reg;
    assign port_on = port_en_reg && sync_reg;
    assign rx_en = port_on && (continuous_receive_enable_reg || (single_receive_enable_reg && clock_source_select_reg));
    assign tx_on = port_on && transmit_enable_reg && !rx_en;
    assign brg_run = transmit_enable_reg || continuous_receive_enable_reg || single_receive_enable_reg;
    assign tick = brg_run && baud_cnt_reg == 8'h00;
    assign clk_run = port_on && clock_source_select_reg && (rx_en || (tx_on && tx_busy_reg));
    always_ff @(posedge clk) begin
        if (!rst_n)
            baud_cnt_reg <= `USR_RESET_BYTE;
        else if (!brg_run || baud_cnt_reg == 8'h00)
            baud_cnt_reg <= divisor_reg;
        else
            baud_cnt_reg <= baud_cnt_reg - 8'h01;
    end
    always_ff @(posedge clk) begin
        if (!rst_n || !clock_source_select_reg || !port_on || !brg_run)
            ck_reg <= 1'b0;
        else if (tick && ck_reg)
            ck_reg <= 1'b0;
        else if (tick && clk_run)
            ck_reg <= 1'b1;
    end
    // master edges come from the generator, slave edges from the pin
    assign rise_ev = clock_source_select_reg ? (tick && !ck_reg && clk_run)
                              : (port_on && ck_stable_reg && !ck_prev_reg);
    assign fall_ev = clock_source_select_reg ? (tick && ck_reg)
                              : (port_on && !ck_stable_reg && ck_prev_reg);
    // ---------------------------------------------------------------
    // receiver
    // ---------------------------------------------------------------
    logic [3:0] rx_cnt_reg, rx_last;
    usr_pkg::usr_word_t rsr_reg, rx_asm, rx_word;
    assign rx_last = rx9_en_reg ? `USR_BITS_9_LAST : `USR_BITS_8_LAST;
    assign word_done = rx_en && fall_ev && rx_cnt_reg == rx_last;
    assign rx_asm = {dt_stable_reg, rsr_reg[8:1]};
    assign rx_word = rx9_en_reg ? rx_asm : {1'b0, rx_asm[8:1]};
    always_ff @(posedge clk) begin
        if (!rst_n || !rx_en) begin
            rx_cnt_reg <= 4'h0;
            rsr_reg <= 9'h000;
        end else if (fall_ev) begin
            rsr_reg <= rx_asm;
            rx_cnt_reg <= (rx_cnt_reg == rx_last) ? 4'h0
                                                  : rx_cnt_reg + 4'h1;
        end
    end
    // ---------------------------------------------------------------
    // receive fifo
    // ---------------------------------------------------------------
    usr_pkg::usr_word_t fifo_mem [RX_FIFO_DEPTH];
    logic [PW-1:0] wr_ptr_reg, rd_ptr_reg;
    logic [PW:0] fifo_cnt_reg;
    logic rx_flag;
    assign full = fifo_cnt_reg == FULL_CNT;
    assign push = word_done && !overrun_error_reg && !full;
    assign overrun = word_done && full;
    assign pop = take && !hwrite && hit(a_idx, `USR_IDX_RECEIVE_DATA)
                 && fifo_cnt_reg != '0;
    assign rx_flag = fifo_cnt_reg != '0;
    always_ff @(posedge clk) begin
        if (push)
            fifo_mem[wr_ptr_reg] <= rx_word;
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            fifo_cnt_reg <= '0;
        end else begin
            if (push)
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (pop)
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            case ({push, pop})
                2'b10: fifo_cnt_reg <= fifo_cnt_reg + 1'b1;
                2'b01: fifo_cnt_reg <= fifo_cnt_reg - 1'b1;
                default: fifo_cnt_reg <= fifo_cnt_reg;
            endcase
        end
    end
    // ---------------------------------------------------------------
    // transmitter
    // ---------------------------------------------------------------
    logic [8:0] txbuf_reg, tsr_reg;
    logic txbuf_full_reg, transmit_flag_reg, dout_reg, tx_load, buf_wr;
    logic [3:0] tx_cnt_reg, tx_bits;
    assign buf_wr = wr_hit(wr_pend_reg, wr_idx_reg, `USR_IDX_TRANSMIT_BUFFER);
    assign tx_load = transmit_enable_reg && !tx_busy_reg && txbuf_full_reg;
    assign tx_bits = tx9_reg ? `USR_BITS_9_LAST + 4'h1
                             : `USR_BITS_8_LAST + 4'h1;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            txbuf_reg <= 9'h000;
            txbuf_full_reg <= 1'b0;
        end else if (buf_wr) begin
            txbuf_reg <= {transmit_ninth_bit_reg, wd};
            txbuf_full_reg <= 1'b1;
        end else if (tx_load) begin
            txbuf_full_reg <= 1'b0;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n)
            transmit_flag_reg <= 1'b0;
        else if (tx_load)
            transmit_flag_reg <= 1'b1;
        else if (buf_wr)
            transmit_flag_reg <= 1'b0;
    end
    always_ff @(posedge clk) begin
        if (!rst_n || !transmit_enable_reg) begin
            tx_busy_reg <= 1'b0;
            tx_cnt_reg <= 4'h0;
            tsr_reg <= 9'h000;
            dout_reg <= 1'b0;
        end else if (tx_load) begin
            tsr_reg <= tx9_reg ? txbuf_reg : {1'b0, txbuf_reg[7:0]};
            tx_busy_reg <= 1'b1;
        end else if (tx_on && tx_busy_reg) begin
            if (rise_ev && tx_cnt_reg < tx_bits) begin
                dout_reg <= tsr_reg[0];
                tsr_reg <= {1'b0, tsr_reg[8:1]};
                tx_cnt_reg <= tx_cnt_reg + 4'h1;
            end else if (fall_ev && tx_cnt_reg == tx_bits) begin
                tx_busy_reg <= 1'b0;
                tx_cnt_reg <= 4'h0;
            end
        end
    end
    // ---------------------------------------------------------------
    // pins, requests and read mux
    // ---------------------------------------------------------------
    assign shift_clock_pin_out = ck_reg;
    assign shift_clock_pin_oe_n = !(port_on && clock_source_select_reg
                                    && (transmit_enable_reg || rx_en));
    assign serial_data_pin_out = dout_reg;
    assign serial_data_pin_oe_n = !tx_on;
    assign rx_irq = rx_flag && pie_reg[`USR_RX_IRQ_ENABLE_BIT];
    assign tx_irq = transmit_flag_reg && pie_reg[`USR_TX_IRQ_ENABLE_BIT];
    assign wake_request = core_sleep && (rx_irq || tx_irq);
    assign branch_request = interrupt_control_reg[`USR_GLOBAL_IRQ_ENABLE_BIT]
                            && interrupt_control_reg[`USR_PERIPHERAL_IRQ_GATE_BIT]
                            && (rx_irq || tx_irq);
    assign branch_vector = `USR_IRQ_VECTOR;
    always_comb begin
        rd_mux = 8'h00;
        if (hit(a_idx, `USR_IDX_INTERRUPT_CONTROL))
            rd_mux = interrupt_control_reg;
        else if (hit(a_idx, `USR_IDX_IRQ_FLAGS)) begin
            rd_mux[`USR_RECEIVE_FLAG_BIT] = rx_flag;
            rd_mux[`USR_TRANSMIT_FLAG_BIT] = transmit_flag_reg;
        end else if (hit(a_idx, `USR_IDX_RX_STATUS_CONTROL))
            rd_mux = {port_en_reg, rx9_en_reg, single_receive_enable_reg, continuous_receive_enable_reg, 2'h0,
                      overrun_error_reg, fifo_mem[rd_ptr_reg][8] && rx_flag};
        else if (hit(a_idx, `USR_IDX_RECEIVE_DATA))
            rd_mux = rx_flag ? fifo_mem[rd_ptr_reg][7:0] : 8'h00;
        else if (hit(a_idx, `USR_IDX_IRQ_ENABLE))
            rd_mux = pie_reg;
        else if (hit(a_idx, `USR_IDX_TX_STATUS_CONTROL))
            rd_mux = {clock_source_select_reg, tx9_reg, transmit_enable_reg, sync_reg, 1'b0,
                      brgh_reg, !tx_busy_reg, transmit_ninth_bit_reg};
        else if (hit(a_idx, `USR_IDX_BAUD_DIVISOR))
            rd_mux = divisor_reg;
    end
    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_handoff;
        tx_busy_reg && transmit_flag_reg && !txbuf_full_reg;
    endsequence
    sequence s_pushed;
        fifo_cnt_reg == $past(fifo_cnt_reg) + 1'b1 ##0 rx_flag;
    endsequence
    rx_fall_sample_a: assert property (
        rx_en && !fall_ev && !$past(fall_ev) ##1 rx_en
        |-> rx_cnt_reg == $past(rx_cnt_reg))
        else $error("receive bit count moved without falling edge");
    single_stop_a: assert property (
        word_done && single_receive_enable_reg && !continuous_receive_enable_reg && clock_source_select_reg && !wr_pend_reg
        |=> !single_receive_enable_reg ##1 !rx_en [*2])
        else $error("single reception did not stop");
    cont_keep_a: assert property (
        word_done && continuous_receive_enable_reg && !wr_pend_reg |=> single_receive_enable_reg == $past(single_receive_enable_reg))
        else $error("continuous reception changed single enable");
    fifo_push_a: assert property (
        word_done && !overrun_error_reg && !full && !pop |=> s_pushed)
        else $error("finished word not stored");
    irq_gate_a: assert property (
        !pie_reg[`USR_RX_IRQ_ENABLE_BIT] |-> !rx_irq)
        else $error("receive request without enable");
    flag_empty_a: assert property (
        pop && fifo_cnt_reg == 1 && !push |=> !rx_flag)
        else $error("receive flag stayed set after fifo emptied");
    overrun_set_a: assert property (
        word_done && full && !pop |=> overrun_error_reg && full)
        else $error("overrun not flagged");
    overrun_hold_a: assert property (
        overrun_error_reg && continuous_receive_enable_reg ##1 continuous_receive_enable_reg |-> overrun_error_reg)
        else $error("overrun cleared while continuous enable set");
    overrun_block_a: assert property (
        overrun_error_reg && !pop |=> fifo_cnt_reg == $past(fifo_cnt_reg))
        else $error("transfer into fifo during overrun");
    tx_handoff_a: assert property (
        tx_load && !buf_wr |=> s_handoff)
        else $error("transmit handoff incomplete");
    tx_rise_a: assert property (
        transmit_enable_reg && $changed(dout_reg) |-> $past(rise_ev && tx_on))
        else $error("transmit data moved off rising edge");
    brg_hold_a: assert property (
        !brg_run ##1 !brg_run |-> baud_cnt_reg == $past(divisor_reg) && !tick)
        else $error("baud generator ran while disabled");
    wake_a: assert property (
        core_sleep && transmit_flag_reg && pie_reg[`USR_TX_IRQ_ENABLE_BIT]
        |-> wake_request)
        else $error("no wake on transmit flag");
endmodule

// ===== usr_map.svh
// register indices, field positions and reset values of the serial port
`ifndef USR_MAP_SVH
`define USR_MAP_SVH
// ---------------------------------------------------------------
// register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define USR_IDX_INTERRUPT_CONTROL 10'h00b
`define USR_IDX_IRQ_FLAGS 10'h00c
`define USR_IDX_RX_STATUS_CONTROL 10'h018
`define USR_IDX_TRANSMIT_BUFFER 10'h019
`define USR_IDX_RECEIVE_DATA 10'h01a
`define USR_IDX_IRQ_ENABLE 10'h08c
`define USR_IDX_TX_STATUS_CONTROL 10'h098
`define USR_IDX_BAUD_DIVISOR 10'h099
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define USR_GLOBAL_IRQ_ENABLE_BIT 7
`define USR_PERIPHERAL_IRQ_GATE_BIT 6
`define USR_RECEIVE_FLAG_BIT 5
`define USR_TRANSMIT_FLAG_BIT 4
`define USR_RX_IRQ_ENABLE_BIT 5
`define USR_TX_IRQ_ENABLE_BIT 4
`define USR_PORT_ENABLE_BIT 7
`define USR_NINTH_RX_ENABLE_BIT 6
`define USR_SINGLE_RX_BIT 5
`define USR_CONT_RX_BIT 4
`define USR_FRAMING_ERROR_BIT 2
`define USR_OVERRUN_BIT 1
`define USR_RX_NINTH_BIT 0
`define USR_CLOCK_SOURCE_BIT 7
`define USR_NINTH_TX_ENABLE_BIT 6
`define USR_TX_ENABLE_BIT 5
`define USR_SYNC_SELECT_BIT 4
`define USR_HIGH_BAUD_BIT 2
`define USR_TX_SHIFT_EMPTY_BIT 1
`define USR_TX_NINTH_BIT 0
// ---------------------------------------------------------------
// reset values, counts and constants
// ---------------------------------------------------------------
`define USR_RESET_BYTE 8'h00
`define USR_TX_STATUS_RESET 8'h02
`define USR_BITS_8_LAST 4'h7
`define USR_BITS_9_LAST 4'h8
`define USR_IRQ_VECTOR 14'h0004
`define USR_HSIZE_WORD 3'h2
`endif

// ===== usr_pkg.sv
// types shared by the serial port design
package usr_pkg;
    typedef enum logic [1:0] {
        USR_TRANS_IDLE,
        USR_TRANS_BUSY,
        USR_TRANS_NONSEQ,
        USR_TRANS_SEQ
    } usr_htrans_e;
    typedef logic [8:0] usr_word_t;
endpackage

// ===== usr_link_partner.sv
// far-side serial partner: data source and external shift clock
`timescale 1ns/1ps
module usr_link_partner (
    input wire logic ck_wire,
    input wire logic dt_wire,
    input wire logic slave,
    input wire logic [3:0] nbits,
    output logic ck_drive,
    output logic dt_drive
);
    logic [8:0] rx_q[$];
    logic [8:0] cur;
    logic [8:0] got;
    logic busy;
    int idx;
    event word_done;
    initial begin
        ck_drive = 1'b0;
        dt_drive = 1'b0;
        busy = 1'b0;
        idx = 0;
    end
    // ------------------------------------------------------------
    // data after each rising master clock, lsb first
    // ------------------------------------------------------------
    always @(posedge ck_wire) begin
        if (!slave) begin
            if (!busy && rx_q.size() != 0) begin
                cur = rx_q.pop_front();
                busy = 1'b1;
            end
            if (busy) begin
                dt_drive <= cur[idx];
                idx = idx + 1;
                if (idx == int'(nbits)) begin
                    idx = 0;
                    busy = 1'b0;
                end
            end else begin
                dt_drive <= ~dt_drive;
            end
        end
    end
    // ------------------------------------------------------------
    // one framed word of clock, sampled late in the low phase
    // ------------------------------------------------------------
    task automatic clock_word();
        int i;
        got = 9'h000;
        for (i = 0; i < int'(nbits); i++) begin
            ck_drive = 1'b1;
            #40 ck_drive = 1'b0;
            #40 got[i] = dt_wire;
        end
        -> word_done;
    endtask
endmodule

// ===== tb_usart_sync_rx_and_slave_tx.sv
// self-checking bench of the synchronous serial port
`timescale 1ns/1ps
`include "usr_map.svh"
module tb_usart_sync_rx_and_slave_tx;
    logic clk, rst_n, hsel, hwrite, hready, core_sleep, hreadyout, hresp;
    logic [11:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, last_rd;
    logic rx_irq, tx_irq, wake_request, branch_request, rd_phase, rd_chk;
    logic [13:0] branch_vector;
    logic ck_out, ck_oe_n, dt_out, dt_oe_n, ck_drive, dt_drive, slave;
    logic [3:0] nbits;
    logic [63:0] exp_q[$];
    logic [63:0] me;
    logic [8:0] exp_tx[$];
    logic [8:0] w0, w1, w2;
    logic [9:0] ridx[8];
    int errors, n_checks, i;
    wire ck_wire = ck_oe_n ? ck_drive : ck_out;
    wire dt_wire = dt_oe_n ? dt_drive : dt_out;
    assign hready = hreadyout;
    always #4 clk = ~clk;
    usr_serial_port i_dut (.clk(clk), .rst_n(rst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .core_sleep(core_sleep),
        .rx_irq(rx_irq), .tx_irq(tx_irq), .wake_request(wake_request),
        .branch_request(branch_request), .branch_vector(branch_vector),
        .shift_clock_pin_in(ck_wire), .shift_clock_pin_out(ck_out),
        .shift_clock_pin_oe_n(ck_oe_n), .serial_data_pin_in(dt_wire),
        .serial_data_pin_out(dt_out), .serial_data_pin_oe_n(dt_oe_n));
    usr_link_partner i_partner (.ck_wire(ck_wire), .dt_wire(dt_wire),
        .slave(slave), .nbits(nbits), .ck_drive(ck_drive),
        .dt_drive(dt_drive));
    // ------------------------------------------------------------
    // bus tasks and result monitors
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] e);
        n_checks++;
        if (got !== e) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, e);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [9:0] ix,
                       input logic [31:0] d, input logic [63:0] m_e,
                       input logic chk);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {ix, 2'b00};
        hwrite <= w;
        hsize <= `USR_HSIZE_WORD;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        rd_phase <= !w;
        rd_chk <= chk;
        if (!w && chk) exp_q.push_back(m_e);
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rd_phase <= 1'b0;
    endtask
    task automatic wr(input logic [9:0] ix, input logic [7:0] d);
        bus(1'b1, ix, {24'h0, d}, 64'h0, 1'b0);
    endtask
    task automatic rd(input logic [9:0] ix, input logic [7:0] m,
                      input logic [7:0] e);
        bus(1'b0, ix, 32'h0, {24'h0, m, 24'h0, e}, 1'b1);
    endtask
    task automatic poll(input logic [9:0] ix, input logic [7:0] m,
                        input logic [7:0] v);
        int k;
        for (k = 0; k < 600; k++) begin
            bus(1'b0, ix, 32'h0, 64'h0, 1'b0);
            #1;
            if ((last_rd[7:0] & m) === v) return;
        end
        check(last_rd & {24'h0, m}, {24'h0, v});
    endtask
    always @(posedge clk) begin
        if (rd_phase === 1'b1) begin
            last_rd = hrdata;
            if (rd_chk === 1'b1) begin
                me = exp_q.pop_front();
                check(hrdata & me[63:32], me[31:0]);
            end
        end
    end
    always @(i_partner.word_done) check(i_partner.got, exp_tx.pop_front());
    initial begin
        #300000;
        errors++;
        complete_run();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {clk, rst_n, hsel, hwrite, core_sleep, slave, rd_phase} = 7'h00;
        {haddr, htrans, hwdata, rd_chk} = '0;
        hsize = 3'h2;
        nbits = 4'h8;
        ridx = '{`USR_IDX_IRQ_FLAGS, `USR_IDX_RX_STATUS_CONTROL,
            `USR_IDX_RECEIVE_DATA, `USR_IDX_IRQ_ENABLE,
            `USR_IDX_TX_STATUS_CONTROL, `USR_IDX_BAUD_DIVISOR,
            `USR_IDX_INTERRUPT_CONTROL, 10'h3ff};
        void'($urandom(32'haa57));
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i < 8; i++) rd(ridx[i], 8'hfe, (i == 4) ? 8'h02 : 8'h00);
        check({30'h0, hreadyout, hresp}, 32'h2);
        $display("test reset_values done");
        w0 = 9'($urandom());
        i_partner.rx_q.push_back({1'b0, w0[7:0]});
        wr(`USR_IDX_BAUD_DIVISOR, 8'h07);
        wr(`USR_IDX_TX_STATUS_CONTROL, 8'h90);
        wr(`USR_IDX_IRQ_ENABLE, 8'h20);
        wr(`USR_IDX_RX_STATUS_CONTROL, 8'ha0);
        #1 check(ck_oe_n, 1'b0);
        poll(`USR_IDX_IRQ_FLAGS, 8'h20, 8'h20);
        check(rx_irq, 1'b1);
        rd(`USR_IDX_RX_STATUS_CONTROL, 8'hff, 8'h80);
        rd(`USR_IDX_RECEIVE_DATA, 8'hff, w0[7:0]);
        rd(`USR_IDX_IRQ_FLAGS, 8'h20, 8'h00);
        $display("test single_receive done");
        nbits = 4'h9;
        w0 = 9'($urandom());
        w1 = 9'($urandom());
        w2 = 9'($urandom());
        i_partner.rx_q = '{w0, w1, w2};
        wr(`USR_IDX_IRQ_ENABLE, 8'h00);
        wr(`USR_IDX_RX_STATUS_CONTROL, 8'hf0);
        poll(`USR_IDX_RX_STATUS_CONTROL, 8'h02, 8'h02);
        check(rx_irq, 1'b0);
        rd(`USR_IDX_RX_STATUS_CONTROL, 8'hdf, {7'h69, w0[8]});
        rd(`USR_IDX_RECEIVE_DATA, 8'hff, w0[7:0]);
        rd(`USR_IDX_RX_STATUS_CONTROL, 8'h03, {7'h01, w1[8]});
        rd(`USR_IDX_RECEIVE_DATA, 8'hff, w1[7:0]);
        rd(`USR_IDX_IRQ_FLAGS, 8'h20, 8'h00);
        wr(`USR_IDX_RX_STATUS_CONTROL, 8'h80);
        rd(`USR_IDX_RX_STATUS_CONTROL, 8'h02, 8'h00);
        $display("test continuous_overrun done");
        nbits = 4'h8;
        slave = 1'b1;
        w0 = 9'($urandom() & 8'hff);
        w1 = 9'($urandom() & 8'hff);
        wr(`USR_IDX_TX_STATUS_CONTROL, 8'h30);
        wr(`USR_IDX_IRQ_ENABLE, 8'h10);
        wr(`USR_IDX_INTERRUPT_CONTROL, 8'hc0);
        wr(`USR_IDX_TRANSMIT_BUFFER, w0[7:0]);
        wr(`USR_IDX_TRANSMIT_BUFFER, w1[7:0]);
        core_sleep <= 1'b1;
        rd(`USR_IDX_IRQ_FLAGS, 8'h10, 8'h00);
        #1 check(ck_oe_n, 1'b1);
        exp_tx.push_back(w0);
        i_partner.clock_word();
        repeat (12) @(posedge clk);
        #1 check({wake_request, branch_request}, 2'h3);
        check(branch_vector, 14'h0004);
        rd(`USR_IDX_IRQ_FLAGS, 8'h10, 8'h10);
        exp_tx.push_back(w1);
        i_partner.clock_word();
        repeat (2) @(posedge clk);
        $display("test slave_transmit done");
        complete_run();
    end
endmodule
